/* dv/ebt_sram.sv */
// Behavioural byte-wide memory on the far side of the external pins.
`timescale 1ns/1ns
`default_nettype none
module ebt_sram
	import ebt_pkg::*;
#(
	parameter logic [7:0] HI_PORT = 8'h00
) (
	input  wire logic               hclk,   // Clock.
	input  wire logic               slow,   // Late read answer.
	input  wire ebt_pkg::ebt_pins_t pins,   // Device pins.
	output logic [7:0]              data_in // Data driven back.
);
	logic [7:0]  mem [0:65535];
	logic [7:0]  lo_addr = 8'h00;
	logic [7:0]  last = 8'h00;
	logic        muxed = 1'b0;
	int          rd_cnt = 0;
	logic [15:0] addr;
	// An undriven upper byte resolves to the port latch value.
	assign addr = {pins.addr_hi_en ? pins.addr[15:8] : HI_PORT, muxed ? lo_addr : pins.addr[7:0]};
	always @(posedge hclk) begin
		if (pins.ale) begin
			lo_addr <= pins.wdata;
			muxed <= 1'b1;
		end
		if (!pins.wr_n)
			mem[addr] <= pins.wdata;
		if (!pins.rd_n || !pins.wr_n)
			muxed <= 1'b0;
		rd_cnt <= pins.rd_n ? 0 : rd_cnt + 1;
		if (!pins.rd_n)
			last <= data_in;
	end
	// Before late data settles and after the strobe the bus shows the inverse of its last value.
	assign data_in = (!pins.rd_n && (rd_cnt != 0 || !slow)) ? mem[addr] : ~last;
endmodule
`default_nettype wire

/* dv/ebt_top_chk.sv */
// Assertions on the external pins of the bus timing block.
`timescale 1ns/1ns
`default_nettype none
module ebt_chk
	import ebt_pkg::*;
(
	input wire logic               hclk,    // Clock.
	input wire logic               hresetn, // Reset, active low.
	input wire ebt_pkg::ebt_pins_t pins     // External pins.
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_strobe; !pins.rd_n || !pins.wr_n; endsequence
	sequence s_idle; pins.rd_n && pins.wr_n; endsequence
	property p_ale_high; $rose(pins.ale) |-> ##[1:4] !pins.ale; endproperty
	a_ale_high: assert property (p_ale_high) else $error("latch high too long");
	property p_ale_low; $fell(pins.ale) |-> s_idle ##[1:7] s_strobe; endproperty
	a_ale_low: assert property (p_ale_low) else $error("latch low phase wrong");
	property p_ale_quiet; pins.ale |-> s_idle ##0 pins.wdata_en; endproperty
	a_ale_quiet: assert property (p_ale_quiet) else $error("latch phase pins wrong");
	property p_wr_width; $fell(pins.wr_n) |-> ##[1:16] $rose(pins.wr_n); endproperty
	a_wr_width: assert property (p_wr_width) else $error("write strobe too long");
	property p_rd_width; $fell(pins.rd_n) |-> ##[1:16] $rose(pins.rd_n); endproperty
	a_rd_width: assert property (p_rd_width) else $error("read strobe too long");
	property p_wd_setup; !pins.wr_n |-> pins.wdata_en && !pins.ale; endproperty
	a_wd_setup: assert property (p_wd_setup) else $error("write data not driven");
	property p_wd_stable; !pins.wr_n && !$past(pins.wr_n) |-> $stable(pins.wdata); endproperty
	a_wd_stable: assert property (p_wd_stable) else $error("write data moved");
	property p_wd_hold; $rose(pins.wr_n) |-> ##[0:6] !pins.wdata_en; endproperty
	a_wd_hold: assert property (p_wd_hold) else $error("write data held too long");
	property p_rd_free; !pins.rd_n |-> !pins.wdata_en && pins.wr_n; endproperty
	a_rd_free: assert property (p_rd_free) else $error("pins driven in read");
endmodule
bind ebt_top ebt_chk u_ebt_chk (.hclk(hclk), .hresetn(hresetn), .pins(pins));
`default_nettype wire

/* dv/tb_ext_memory_bus_timing.sv */
// Self-checking testbench for the external bus timing block.
`timescale 1ns/1ns
`default_nettype none
module tb_ext_memory_bus_timing;
	import ebt_pkg::*;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [7:0]  haddr = 8'h00;
	logic [1:0]  htrans = 2'b00;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'b010;
	logic [31:0] hwdata = 32'h0;
	logic        slow = 1'b0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	ebt_pins_t   pins;
	logic [7:0]  data_in;
	int          miscompares = 0;
	int          n_tests = 0;
	int          ale_hi, gap, st_lo;
	logic        hi_en, wide;
	logic [7:0]  hi_val, lo_val, wd_val, t, pg, d;
	logic [4:0]  c;
	logic [15:0] a;
	always #20 hclk = ~hclk;
	ebt_top u_ebt_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pins(pins), .data_in(data_in));
	ebt_sram u_ebt_sram (.hclk(hclk), .slow(slow), .pins(pins), .data_in(data_in));
	always @(posedge hclk) begin
		if (!pins.rd_n || !pins.wr_n) begin
			st_lo++;
			hi_en = pins.addr_hi_en;
			hi_val = pins.addr[15:8];
			wd_val = pins.wdata;
			if (ale_hi == 0)
				lo_val = pins.addr[7:0];
		end else if (pins.ale) begin
			ale_hi++;
			lo_val = pins.wdata;
		end else if (ale_hi != 0 && st_lo == 0)
			gap++;
	end
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic rdy;
		int n;
		n = 0;
		do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 20);
		if (hreadyout !== 1'b1) begin
			miscompares++;
			report_and_stop;
		end
	endtask
	task automatic ahb(input logic [7:0] ad, input logic w, input logic [31:0] wd,
		output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= ad;
		hwrite <= w;
		htrans <= 2'b10;
		rdy();
		htrans <= 2'b00;
		hwdata <= wd;
		rdy();
		r = hrdata;
	endtask
	task automatic move(input logic wr);
		logic [31:0] r;
		int n;
		ale_hi = 0;
		gap = 0;
		st_lo = 0;
		ahb(EBT_OFF_CMD, 1'b1, {6'h00, wide, wr, d, a}, r);
		n = 0;
		do ahb(EBT_OFF_STATUS, 1'b0, 32'h0, r); while (r[0] !== 1'b0 && ++n < 100);
		chk("busy", 32'h0, {31'h0, r[0]});
		if (r[0] !== 1'b0)
			report_and_stop;
		chk("ale high", c[4] ? 0 : c[1:0] + 1, ale_hi);
		if (!c[4])
			chk("ale low", c[1:0] + 1 + t[7:6], gap);
		chk("strobe", t[5:2] + 1, st_lo);
		chk("low addr", 32'(a[7:0]), 32'(lo_val));
		chk("hi en", wide || c[3:2] == 2'b10, hi_en);
		if (hi_en === 1'b1)
			chk("hi addr", wide ? a[15:8] : pg, hi_val);
		if (wr)
			chk("wdata", 32'(d), 32'(wd_val));
		else begin
			ahb(EBT_OFF_RDATA, 1'b0, 32'h0, r);
			chk("rdata", 32'(d), {24'h0, r[7:0]});
		end
	endtask
	initial begin
		logic [31:0] r;
		void'($urandom(32'h2cb9));
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		ahb(EBT_OFF_TIMING, 1'b0, 32'h0, r);
		chk("timing reset", 32'hff, r);
		ahb(EBT_OFF_CONFIG, 1'b0, 32'h0, r);
		chk("config reset", 32'h1f, r);
		ahb(8'h1c, 1'b0, 32'h0, r);
		chk("unmapped", 32'h0, r);
		for (int m = 1; m < 8; m++) begin
			for (int k = 0; k < 4 && m != 4; k++) begin
				t = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
				c = {m[2:0], (k == 0) ? 2'h0 : (k == 1) ? 2'h3 : 2'($urandom)};
				{a, d, pg} = 32'($urandom);
				wide = k[0];
				slow <= k[1] && t[5:2] != 4'h0;
				ahb(EBT_OFF_TIMING, 1'b1, 32'(t), r);
				ahb(EBT_OFF_TIMING, 1'b0, 32'h0, r);
				chk("timing", 32'(t), r);
				ahb(EBT_OFF_CONFIG, 1'b1, 32'(c), r);
				ahb(EBT_OFF_PAGE, 1'b1, 32'(pg), r);
				move(1'b1);
				move(1'b0);
			end
		end
		report_and_stop;
	end
endmodule
`default_nettype wire

/* rtl/ebt_cnt.sv */
// Down counter that paces one phase of an external bus cycle.
`timescale 1ns/1ns
`default_nettype none
module ebt_cnt #(
	parameter int W = 5
) (
	input  wire logic         hclk,    // System clock.
	input  wire logic         hresetn, // Asynchronous reset, active low.
	input  wire logic         load,    // Load a new phase length.
	input  wire logic [W-1:0] len,     // Phase length in clock periods minus one.
	output logic              done     // High in the last cycle of the phase.
);
	logic [W-1:0] cnt_reg;
	initial begin
		if (W < 5) $error("ebt_cnt: width too small");
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) cnt_reg <= '0;
		else if (load) cnt_reg <= len;
		else if (cnt_reg != '0) cnt_reg <= cnt_reg - 1'b1;
	end
	assign done = (cnt_reg == '0);
endmodule
`default_nettype wire

/* rtl/ebt_pkg.sv */
// Package with register map, field layout and types of the external bus timing block.
package ebt_pkg;
	localparam logic [7:0] EBT_OFF_TIMING    = 8'h00;
	localparam logic [7:0] EBT_OFF_CONFIG    = 8'h04;
	localparam logic [7:0] EBT_OFF_PAGE      = 8'h08;
	localparam logic [7:0] EBT_OFF_CMD       = 8'h0c;
	localparam logic [7:0] EBT_OFF_STATUS    = 8'h10;
	localparam logic [7:0] EBT_OFF_RDATA     = 8'h14;
	localparam logic [7:0] EBT_TIMING_RESET  = 8'hff;
	localparam logic [4:0] EBT_CONFIG_RESET  = 5'h1f;
	localparam logic [7:0] EBT_PAGE_RESET    = 8'h00;
	localparam int         EBT_SETUP_MSB     = 7;
	localparam int         EBT_SETUP_LSB     = 6;
	localparam int         EBT_WIDTH_MSB     = 5;
	localparam int         EBT_WIDTH_LSB     = 2;
	localparam int         EBT_HOLD_MSB      = 1;
	localparam int         EBT_HOLD_LSB      = 0;
	localparam int         EBT_MUXSEL_BIT    = 4;
	localparam int         EBT_MODE_MSB      = 4;
	localparam int         EBT_MODE_LSB      = 2;
	localparam int         EBT_OVERHEAD      = 4;
	localparam int         EBT_CMD_WRITE_BIT = 24;
	localparam int         EBT_CMD_WIDE_BIT  = 25;

	typedef struct packed {
		logic [15:0] addr;
		logic        addr_hi_en;
		logic [7:0]  wdata;
		logic        wdata_en;
		logic        ale;
		logic        rd_n;
		logic        wr_n;
	} ebt_pins_t;

	typedef struct packed {
		logic [1:0] setup;
		logic [3:0] width;
		logic [1:0] hold;
		logic [1:0] ale;
		logic       muxed;
	} ebt_timing_t;
endpackage

/* rtl/ebt_top.sv */
// External memory bus timing engine with an AHB-Lite register slave.
// Contract
// RL1: Modes 101, 110, 111 run 16-bit moves on separate address and data pins.
// RL2: Modes 101, 111 run 8-bit moves non-multiplexed with upper byte undriven.
// RL3: Mode 110 runs 8-bit moves non-multiplexed with upper byte from page.
// RL4: Modes 001, 010, 011 run 16-bit moves multiplexed on shared pins.
// RL5: Modes 001, 011 run 8-bit multiplexed moves with upper byte undriven.
// RL6: Mode 010 runs 8-bit multiplexed moves with upper byte from page.
// RL7: Timing register holds setup 7-6, width 5-2, hold 1-0, resets ff.
// RL8: Latch strobe stays high 1 to 4 clock periods in multiplexed cycles.
// RL9: Latch strobe stays low 1 to 4 periods after its high phase.
// RL10: Write data leads strobe end by 1 to 19 periods; multiplexed cycles also drive it through the latch low phase, up to 23.
// RL11: Write data stays driven 0 to 3 periods after strobe end.
// RL12: All timing counts whole system clock periods.
// RL13: Move length is setup plus width plus hold plus 4 periods; multiplexed moves also add the latch high and low phases.
// RL14: Latch codes 00 to 11 give 1 to 4 periods, only when multiplexed.
// RL15: Reset loads maximum setup and hold delays.
// RL16: Setup 0-3, strobe 1-16, hold 0-3 periods.
// RL17: Memory holds read data valid until the read strobe ends.
`timescale 1ns/1ns
`default_nettype none
module ebt_top
	import ebt_pkg::*;
(
	input  wire logic        hclk,      // System clock, 25 MHz.
	input  wire logic        hresetn,   // Asynchronous reset, active low.
	input  wire logic        hsel,      // Slave select.
	input  wire logic [7:0]  haddr,     // Byte address.
	input  wire logic [1:0]  htrans,    // Transfer type.
	input  wire logic        hwrite,    // Write when high.
	input  wire logic [2:0]  hsize,     // Transfer size.
	input  wire logic [31:0] hwdata,    // Write data.
	input  wire logic        hready,    // Bus ready in.
	output logic [31:0]      hrdata,    // Read data.
	output logic             hreadyout, // Slave ready.
	output logic             hresp,     // Response, always OKAY.
	output ebt_pkg::ebt_pins_t pins,    // External bus pins.
	input  wire logic [7:0]  data_in    // Data pins as read back.
);
	import ebt_pkg::*;

	typedef enum logic [2:0] {EBT_IDLE, EBT_ALEH, EBT_ALEL, EBT_SETUP, EBT_STROBE,
		EBT_HOLD, EBT_TAIL} ebt_state_t;

	ebt_state_t  state_reg, state_next;
	logic [7:0]  timing_reg;
	logic [4:0]  config_reg;
	logic [7:0]  page_reg;
	logic [7:0]  rdata_reg;
	logic [25:0] cmd_reg;
	// Write requests are remembered for one cycle, because the data phase follows the address.
	logic        wr_pend_reg;
	logic [7:0]  waddr_reg;
	logic [31:0] hrdata_reg;
	ebt_pins_t   pins_reg, pins_next;
	ebt_timing_t tm;
	logic        done;
	logic        load;
	logic [4:0]  len;
	// The command as it will stand once the current write lands.
	logic [25:0] cmd_cur;

	// The tail phase length is the overhead less the launch and strobe-end cycles.
	initial begin
		if (EBT_OVERHEAD < 2) begin
			$error("ebt_top: overhead too small for the tail phase");
		end
		if (EBT_OVERHEAD > 33) begin
			$error("ebt_top: overhead too large for the phase counter");
		end
	end

	// Timing fields decoded from the registers.
	assign tm.setup = timing_reg[EBT_SETUP_MSB:EBT_SETUP_LSB]; // [RL7]
	assign tm.width = timing_reg[EBT_WIDTH_MSB:EBT_WIDTH_LSB]; // [RL7]
	assign tm.hold  = timing_reg[EBT_HOLD_MSB:EBT_HOLD_LSB];   // [RL7]
	assign tm.ale   = config_reg[1:0];
	assign tm.muxed = ~config_reg[EBT_MUXSEL_BIT];             // [RL14]

	wire [2:0] mode      = config_reg[EBT_MODE_MSB:EBT_MODE_LSB];
	wire       mode_ok   = (mode != 3'b000) && (mode != 3'b100);
	// A move starts in the cycle the command lands, so the pins read the incoming word then.
	// Reading the stored word instead would launch the first cycle with the previous command.
	wire       cmd_wide  = cmd_cur[EBT_CMD_WIDE_BIT];
	wire       cmd_write = cmd_cur[EBT_CMD_WRITE_BIT];
	// Bank selection only in modes 110 and 010; 16-bit moves always drive the upper byte.
	wire       bank_sel  = (mode == 3'b110) || (mode == 3'b010);         // [RL3] [RL6]
	wire       hi_drive  = cmd_wide || bank_sel;                        // [RL1] [RL2] [RL5]
	wire [7:0] hi_byte   = cmd_wide ? cmd_cur[15:8] : page_reg;
	wire       busy      = (state_reg != EBT_IDLE);

	// Bus decode.
	wire       addr_ph   = hsel && hready && htrans[1];
	wire       wr_hit    = wr_pend_reg;
	wire       w_timing  = wr_hit && (waddr_reg == EBT_OFF_TIMING);
	wire       w_config  = wr_hit && (waddr_reg == EBT_OFF_CONFIG);
	wire       w_page    = wr_hit && (waddr_reg == EBT_OFF_PAGE);
	wire       w_cmd     = wr_hit && (waddr_reg == EBT_OFF_CMD) && !busy && mode_ok;
	assign cmd_cur = w_cmd ? hwdata[25:0] : cmd_reg;

	// Read decode on the address phase; unmapped offsets read as zero.
	wire        r_timing = (haddr == EBT_OFF_TIMING);
	wire        r_config = (haddr == EBT_OFF_CONFIG);
	wire        r_page   = (haddr == EBT_OFF_PAGE);
	wire        r_cmd    = (haddr == EBT_OFF_CMD);
	wire        r_status = (haddr == EBT_OFF_STATUS);
	wire        r_rdata  = (haddr == EBT_OFF_RDATA);
	logic [31:0] rd_mux;
	always_comb begin
		if (r_timing) begin
			rd_mux = {24'h0, timing_reg};
		end else if (r_config) begin
			rd_mux = {27'h0, config_reg};
		end else if (r_page) begin
			rd_mux = {24'h0, page_reg};
		end else if (r_cmd) begin
			rd_mux = {6'h0, cmd_reg};
		end else if (r_status) begin
			rd_mux = {31'h0, busy};
		end else if (r_rdata) begin
			rd_mux = {24'h0, rdata_reg};
		end else begin
			rd_mux = 32'h0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			waddr_reg   <= 8'h00;
			hrdata_reg  <= 32'h0;
		end else begin
			wr_pend_reg <= addr_ph && hwrite;
			if (addr_ph) waddr_reg <= haddr;
			if (addr_ph && !hwrite) hrdata_reg <= rd_mux;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			timing_reg <= EBT_TIMING_RESET; // [RL15]
			config_reg <= EBT_CONFIG_RESET;
			page_reg   <= EBT_PAGE_RESET;
		end else begin
			if (w_timing) timing_reg <= hwdata[7:0]; // [RL7]
			if (w_config) config_reg <= hwdata[4:0];
			if (w_page) page_reg <= hwdata[7:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) cmd_reg <= '0;
		else if (w_cmd) cmd_reg <= hwdata[25:0];
	end

	// Phase lengths minus one, in whole clock periods.
	always_comb begin
		state_next = state_reg;
		load       = 1'b0;
		len        = 5'd0;
		case (state_reg)
			EBT_IDLE: begin
				if (w_cmd) begin
					load = 1'b1;
					if (tm.muxed) begin
						state_next = EBT_ALEH;
						len        = {3'b000, tm.ale}; // [RL8] [RL14]
					end else if (tm.setup != 2'd0) begin
						state_next = EBT_SETUP;
						len        = {3'b000, tm.setup} - 5'd1;
					end else begin
						state_next = EBT_STROBE;
						len        = {1'b0, tm.width}; // [RL16]
					end
				end
			end
			EBT_ALEH: begin
				if (done) begin
					state_next = EBT_ALEL;
					load       = 1'b1;
					len        = {3'b000, tm.ale}; // [RL9]
				end
			end
			EBT_ALEL: begin
				if (done) begin
					load = 1'b1;
					if (tm.setup != 2'd0) begin
						state_next = EBT_SETUP;
						len        = {3'b000, tm.setup} - 5'd1;
					end else begin
						state_next = EBT_STROBE;
						len        = {1'b0, tm.width};
					end
				end
			end
			EBT_SETUP: begin
				if (done) begin
					state_next = EBT_STROBE;
					load       = 1'b1;
					len        = {1'b0, tm.width}; // [RL16] [RL12]
				end
			end
			EBT_STROBE: begin
				if (done) begin
					load = 1'b1;
					if (tm.hold != 2'd0) begin
						state_next = EBT_HOLD;
						len        = {3'b000, tm.hold} - 5'd1; // [RL11]
					end else begin
						state_next = EBT_TAIL;
						len        = 5'(EBT_OVERHEAD - 2);
					end
				end
			end
			EBT_HOLD: begin
				if (done) begin
					state_next = EBT_TAIL;
					load       = 1'b1;
					len        = 5'(EBT_OVERHEAD - 2); // [RL13]
				end
			end
			EBT_TAIL: begin
				if (done) state_next = EBT_IDLE;
			end
			default: state_next = EBT_IDLE;
		endcase
	end

	ebt_cnt #(.W(5)) u_cnt (
		.hclk    (hclk),
		.hresetn (hresetn),
		.load    (load),
		.len     (len),
		.done    (done)
	);

	// Pin values for the next cycle; write data leads the strobe by the setup phase, plus the latch low phase when multiplexed.
	always_comb begin
		pins_next            = pins_reg;
		pins_next.ale        = (state_next == EBT_ALEH);                      // [RL8]
		pins_next.rd_n       = !((state_next == EBT_STROBE) && !cmd_write);
		pins_next.wr_n       = !((state_next == EBT_STROBE) && cmd_write);
		pins_next.addr_hi_en = (state_next != EBT_IDLE) && hi_drive;            // [RL3] [RL6]
		if (state_next == EBT_ALEH) begin
			pins_next.addr     = {hi_byte, cmd_cur[7:0]};
			pins_next.wdata    = cmd_cur[7:0];                                // [RL4]
			pins_next.wdata_en = 1'b1;
		end else if (state_next == EBT_IDLE) begin
			pins_next.wdata_en = 1'b0;
		end else begin
			pins_next.addr     = {hi_byte, cmd_cur[7:0]};                       // [RL1]
			pins_next.wdata    = cmd_cur[23:16];
			pins_next.wdata_en = cmd_write && (state_next != EBT_TAIL);      // [RL10] [RL11]
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= EBT_IDLE;
			pins_reg  <= '{addr: 16'h0, addr_hi_en: 1'b0, wdata: 8'h0, wdata_en: 1'b0,
				ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1};
			rdata_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			pins_reg  <= pins_next;
			// Read data sampled as the strobe ends.
			if (state_reg == EBT_STROBE && done && !cmd_write) rdata_reg <= data_in; // [RL17]
		end
	end

	assign pins      = pins_reg;
	assign hrdata    = hrdata_reg;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
endmodule
`default_nettype wire
